// ### shared/acm_pkg.sv
// acm_pkg: constants and types for the conversion mode controller.
// assumes a single 10 MHz reference clock.
package acm_pkg;
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned CONV_ADC_NS    = 9_000;
  localparam int unsigned CONV_TEMP_NS   = 27_000;
  localparam int unsigned ACQ_MIN_NS     = 100;
  localparam int unsigned PWRUP_NS       = 2_000;
  localparam int unsigned NS_PER_S       = 1_000_000_000;
  localparam int unsigned CLK_NS         = NS_PER_S / CLK_HZ;
  localparam int unsigned CONV_ADC_CYC   = CONV_ADC_NS / CLK_NS;
  localparam int unsigned CONV_TEMP_CYC  = CONV_TEMP_NS / CLK_NS;
  localparam int unsigned ACQ_MIN_CYC    = (ACQ_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PWRUP_CYC      = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CNT_W          = 9;
  localparam int          CODE_W         = 10;
  localparam int          CODE_STEPS     = 1024;
  localparam logic [2:0]  CH_TEMP        = 3'h0;
  localparam logic [2:0]  CH_RESET       = 3'h0;
  localparam int          TEMP_OFFSET_C  = 103;
  localparam logic [9:0]  CODE_RESET     = 10'h000;
  localparam logic [9:0]  CODE_MIN55     = 10'h0C0;
  localparam logic [9:0]  CODE_PLUS125   = 10'h390;

  typedef enum logic [1:0]
  {
    ST_ACQ  = 2'b00,
    ST_CONV = 2'b01,
    ST_PD   = 2'b10
  } acm_state_t;

  typedef struct packed
  {
    acm_state_t         st;
    logic               cs_n_d;
    logic [CNT_W-1:0]   cnt;
    logic [2:0]         ch;
    logic [CODE_W-1:0]  code;
    logic               busy;
    logic               pd;
    logic               pd_mode;
  } acm_regs_t;
endpackage

// ### hw/acm_temp_code.sv
// acm_temp_code: maps a quarter-degree temperature sample to the output code.
// assumes a signed input in units of 0.25 C, clamped to the code range.
`timescale 1ns/1ns
module acm_temp_code
  import acm_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire logic signed [11:0] i_temp_q,
  output logic        [CODE_W-1:0] o_code
);
  localparam logic signed [12:0] OFS_Q = 13'(TEMP_OFFSET_C * 4);
  logic signed [12:0] sum;

  // code = 4 * (t + 103)
  always_comb sum = 13'(i_temp_q) + OFS_Q;

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      o_code <= CODE_RESET;
    else if (sum < 0)
      o_code <= CODE_RESET;
    else if (sum > 13'(CODE_STEPS - 1))
      o_code <= {CODE_W{1'b1}};
    else
      o_code <= sum[CODE_W-1:0];
  end
endmodule

// ### hw/acm_ctrl.sv
// acm_ctrl: convert-start sequencing, busy, power-down and result coding.
// assumes convert_start_n, channel and sample inputs synchronous to i_ref_clk.
// Summary of operation
// - acquisition starts when a conversion ends with convert-start high, or on the wake rise after power-down, and stops on convert-start falling.
// - results are straight binary over 1024 codes of 2.5 V/1024.
// - channel 000 is the temperature sensor and is selected after reset.
// - temperature code equals four times (degrees plus 103).
// - temperature codes match the table, 0C0 at -55 C and 390 at +125 C.
// - mode is chosen only by convert-start level when the conversion ends.
// - convert-start still low as busy falls powers the device down.
// - after power-down the next convert-start rising edge wakes the device.
// - falling edge holds, starts conversion, raises busy for 9 us or 27 us.
`timescale 1ns/1ns
module acm_ctrl
  import acm_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire logic               i_convert_start_n,
  input  wire logic               i_ch_wr,
  input  wire logic [2:0]         i_ch_sel,
  input  wire logic [CODE_W-1:0]  i_sample,
  input  wire logic signed [11:0] i_temp_q,
  output logic                    o_busy,
  output logic                    o_hold,
  output logic                    o_power_down,
  output logic [2:0]              o_channel,
  output logic [CODE_W-1:0]       o_result
);
  acm_regs_t r_r;
  acm_regs_t r_nxt;
  logic [CODE_W-1:0] temp_code;
  logic              fall;
  logic              rise;
  logic              last;

  // busy lengths in clock samples, first high sample counted as zero
  localparam int BUSY_TEMP_LAST = CONV_TEMP_CYC - 1;
  localparam int BUSY_ADC_LAST  = CONV_ADC_CYC - 1;

  acm_temp_code u_temp
  (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_temp_q  (i_temp_q),
    .o_code    (temp_code)
  );

  function automatic logic [CNT_W-1:0] conv_len(input logic [2:0] ch);
    conv_len = (ch == CH_TEMP) ? CNT_W'(CONV_TEMP_CYC - 1) : CNT_W'(CONV_ADC_CYC - 1);
  endfunction

  assign fall = r_r.cs_n_d && !i_convert_start_n;
  assign rise = !r_r.cs_n_d && i_convert_start_n;
  assign last = (r_r.st == ST_CONV) && (r_r.cnt == '0);

  always_comb
  begin
    r_nxt        = r_r;
    r_nxt.cs_n_d = i_convert_start_n;
    if (i_ch_wr && r_r.st != ST_CONV)
      r_nxt.ch = i_ch_sel;
    case (r_r.st)
      ST_ACQ:
      begin
        if (fall)
        begin
          r_nxt.st   = ST_CONV;
          r_nxt.busy = 1'b1;
          r_nxt.cnt  = conv_len(r_r.ch);
        end
      end
      ST_CONV:
      begin
        if (last)
        begin
          r_nxt.busy = 1'b0;
          // straight binary, temperature channel uses its own code map
          r_nxt.code = (r_r.ch == CH_TEMP) ? temp_code : i_sample;
          // mode decided only by the level at end of conversion
          if (!i_convert_start_n)
          begin
            r_nxt.st      = ST_PD;
            r_nxt.pd      = 1'b1;
            r_nxt.pd_mode = 1'b1;
          end
          else
          begin
            r_nxt.st      = ST_ACQ;
            r_nxt.pd_mode = 1'b0;
          end
        end
        else
          r_nxt.cnt = r_r.cnt - 1'b1;
      end
      ST_PD:
      begin
        if (rise)
        begin
          r_nxt.st = ST_ACQ;
          r_nxt.pd = 1'b0;
        end
      end
      default:
        r_nxt.st = ST_ACQ;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      r_r.st      <= ST_ACQ;
      r_r.cs_n_d  <= 1'b1;
      r_r.cnt     <= '0;
      r_r.ch      <= CH_RESET;
      r_r.code    <= CODE_RESET;
      r_r.busy    <= 1'b0;
      r_r.pd      <= 1'b0;
      r_r.pd_mode <= 1'b0;
    end
    else
      r_r <= r_nxt;
  end

  assign o_busy       = r_r.busy;
  assign o_hold       = (r_r.st == ST_CONV);
  assign o_power_down = r_r.pd;
  assign o_channel    = r_r.ch;
  assign o_result     = r_r.code;

  chk_busy_temp_len: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ($rose(r_r.busy) && r_r.ch == CH_TEMP) |-> ##BUSY_TEMP_LAST r_r.busy ##1 !r_r.busy)
    else $error("busy length wrong on temperature channel");

  chk_busy_adc_len: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ($rose(r_r.busy) && r_r.ch != CH_TEMP) |-> ##BUSY_ADC_LAST r_r.busy ##1 !r_r.busy)
    else $error("busy length wrong on input channel");

  chk_load_temp: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (r_r.st == ST_ACQ && fall && r_r.ch == CH_TEMP) |=> r_r.cnt == BUSY_TEMP_LAST)
    else $error("temperature count not loaded");

  chk_load_adc: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (r_r.st == ST_ACQ && fall && r_r.ch != CH_TEMP) |=> r_r.cnt == BUSY_ADC_LAST)
    else $error("input count not loaded");

  chk_start_busy: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (r_r.st == ST_ACQ && r_r.cs_n_d && !i_convert_start_n) |=> (r_r.busy && o_hold))
    else $error("busy not raised after start");

  chk_pd_entry: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ($fell(r_r.busy) && !$past(i_convert_start_n)) |-> r_r.pd)
    else $error("no power down with start low");

  chk_no_pd: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ($fell(r_r.busy) && $past(i_convert_start_n)) |-> (!r_r.pd && r_r.st == ST_ACQ))
    else $error("power down with start high");

  chk_wake_rise: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (r_r.st == ST_PD && !r_r.cs_n_d && i_convert_start_n) |=> !r_r.pd)
    else $error("no wake on rising start");

  chk_temp_code: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    // minus 55 C in quarter degrees
    ($fell(r_r.busy) && $past(r_r.ch) == CH_TEMP && $past(i_temp_q, 2) == 12'hF24)
      |-> r_r.code == CODE_MIN55)
    else $error("temperature code at -55 C wrong");

  chk_temp_hot: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ($fell(r_r.busy) && $past(r_r.ch) == CH_TEMP && $past(i_temp_q, 2) == 12'h1F4)
      |-> r_r.code == CODE_PLUS125)
    else $error("temperature code at +125 C wrong");

  chk_adc_code: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ($fell(r_r.busy) && $past(r_r.ch) != CH_TEMP) |-> r_r.code == $past(i_sample))
    else $error("input code not passed straight");

  chk_reset_chan: assert property (@(posedge i_ref_clk)
    $fell(i_rst) |-> o_channel == CH_TEMP)
    else $error("channel not temperature after reset");

  // hold is decoded from ST_CONV and busy is its own flag set and cleared on the same transitions, so they never drift apart
  chk_busy_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_busy == o_hold)
    else $error("busy and hold differ");

  // a second start while converting must not reload the count
  chk_no_restart: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (r_r.st == ST_CONV && !last) |=> (r_r.st == ST_CONV && r_r.cnt == $past(r_r.cnt) - 1'b1))
    else $error("conversion count disturbed");

  chk_acq_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (r_r.st == ST_ACQ && !fall) |=> (r_r.st == ST_ACQ && !r_r.busy))
    else $error("acquisition left without start");

  chk_ch_frozen: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (r_r.st == ST_CONV) |=> $stable(r_r.ch))
    else $error("channel changed during conversion");

  chk_ch_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_ch_wr && r_r.st != ST_CONV) |=> r_r.ch == $past(i_ch_sel))
    else $error("channel write not taken");

  chk_result_stands: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !last |=> $stable(r_r.code))
    else $error("result changed outside conversion end");

  chk_pd_state: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    r_r.pd == (r_r.st == ST_PD))
    else $error("power down flag and state differ");

  chk_pd_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (r_r.st == ST_PD && !rise) |=> (r_r.st == ST_PD && r_r.pd))
    else $error("power down left without rising start");

  chk_wake_acq: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (r_r.st == ST_PD && rise) |=> (r_r.st == ST_ACQ && !r_r.busy))
    else $error("wake did not return to acquisition");
endmodule

// ### test/acm_host.sv
// acm_host: host side that pulses convert_start_n and times busy.
// assumes busy is sampled at the rising edge of i_ref_clk.
`timescale 1ns/1ns
module acm_host
  import acm_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_busy,
  output logic      o_convert_start_n
);
  initial o_convert_start_n = 1'b1;
  // returns the number of edges at which busy was seen high
  task automatic convert(input bit mode2, output int hi);
    int w;
    begin
      hi = 0;
      w = 0;
      // two high cycles first, so the fall is a fresh edge
      repeat (ACQ_MIN_CYC + 1) @(posedge i_ref_clk);
      o_convert_start_n <= 1'b0;
      while (i_busy !== 1'b1 && w < 8)
      begin
        @(posedge i_ref_clk);
        w++;
      end
      while (i_busy === 1'b1 && hi < 400)
      begin
        // low pulse spans power-up, then released well before the end
        if (!mode2 && hi == PWRUP_CYC) o_convert_start_n <= 1'b1;
        @(posedge i_ref_clk);
        hi++;
      end
      if (mode2)
      begin
        repeat (3) @(posedge i_ref_clk);
        o_convert_start_n <= 1'b1;
      end
    end
  endtask
endmodule

// ### test/adc_conversion_mode_control_tb.sv
// adc_conversion_mode_control_tb: self-checking bench for acm_ctrl.
// assumes acm_host drives convert_start_n on the rising edge.
`timescale 1ns/1ns
module adc_conversion_mode_control_tb;
  import acm_pkg::*;
  logic                    i_ref_clk = 1'b0;
  logic                    i_rst     = 1'b1;
  logic                    i_ch_wr   = 1'b0;
  logic [2:0]              i_ch_sel  = 3'h0;
  logic [CODE_W-1:0]       i_sample  = 10'h000;
  logic signed [11:0]      i_temp_q  = 12'h000;
  logic                    convert_start_n;
  logic                    o_busy;
  logic                    o_hold;
  logic                    o_power_down;
  logic [2:0]              o_channel;
  logic [CODE_W-1:0]       o_result;
  int                      err_count = 0;
  int                      n_checks  = 0;
  int                      hi;
  always #50 i_ref_clk = ~i_ref_clk;
  acm_ctrl dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_convert_start_n(convert_start_n),
    .i_ch_wr(i_ch_wr), .i_ch_sel(i_ch_sel), .i_sample(i_sample), .i_temp_q(i_temp_q),
    .o_busy(o_busy), .o_hold(o_hold), .o_power_down(o_power_down),
    .o_channel(o_channel), .o_result(o_result));
  acm_host host_u (.i_ref_clk(i_ref_clk), .i_busy(o_busy),
    .o_convert_start_n(convert_start_n));
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    if (err_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic temp_run(input int deg, input bit mode2);
    i_temp_q <= 12'(deg * 4);
    host_u.convert(mode2, hi);
    chk("temp_busy", 16'(hi), 16'(CONV_TEMP_CYC));
    chk("temp_code", 16'(o_result), 16'(4 * (deg + 103)));
    chk("pd_at_end", 16'(o_power_down), 16'(mode2));
    repeat (3) @(posedge i_ref_clk);
    chk("pd_after_rise", 16'(o_power_down), 16'h0000);
  endtask
  task automatic write_ch(input logic [2:0] ch);
    i_ch_sel <= ch;
    i_ch_wr  <= 1'b1;
    @(posedge i_ref_clk);
    i_ch_wr  <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    chk("channel", 16'(o_channel), 16'(ch));
  endtask
  task automatic analog_run();
    write_ch(3'h1);
    i_sample <= 10'h3FF;
    host_u.convert(1'b0, hi);
    chk("adc_busy", 16'(hi), 16'(CONV_ADC_CYC));
    chk("adc_code", 16'(o_result), 16'h03FF);
    chk("hold_acq", 16'(o_hold), 16'h0000);
    write_ch(CH_TEMP);
  endtask
  task automatic refuse_run();
    fork
      host_u.convert(1'b0, hi);
      begin
        repeat (30) @(posedge i_ref_clk);
        i_ch_sel <= 3'h1;
        i_ch_wr  <= 1'b1;
        @(posedge i_ref_clk);
        i_ch_wr  <= 1'b0;
        @(posedge i_ref_clk);
        chk("ch_refused", 16'(o_channel), 16'(CH_TEMP));
      end
    join
    chk("refused_busy", 16'(hi), 16'(CONV_TEMP_CYC));
    chk("refused_code", 16'(o_result), 16'(CODE_PLUS125));
  endtask
  task automatic reset_run();
    write_ch(3'h1);
    i_rst <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    chk("rst2_channel", 16'(o_channel), 16'(CH_RESET));
    chk("rst2_result", 16'(o_result), 16'(CODE_RESET));
    chk("rst2_pd", 16'(o_power_down), 16'h0000);
    i_rst <= 1'b0;
  endtask
  initial
  begin
    repeat (6) @(posedge i_ref_clk);
    chk("rst_channel", 16'(o_channel), 16'h0000);
    chk("rst_busy", 16'(o_busy), 16'h0000);
    i_rst <= 1'b0;
    temp_run(-55, 1'b0);
    temp_run(125, 1'b1);
    analog_run();
    refuse_run();
    reset_run();
    temp_run(0, 1'b0);
    final_report();
  end
  // whole run is near 1,220 cycles; about 16x margin
  initial
  begin
    #2_000_000;
    err_count++;
    final_report();
  end
endmodule
